// ### include/lsfc_pkg.sv
// lsfc_pkg: constants, register map and state codes of the load switch control
// assumes a 40 MHz sys_clk and a byte wide register port
// What this block does
// RULE_01 - enabled and fault free: switch stays on
// RULE_02 - undervoltage or overtemperature always force off
// RULE_03 - blanking: limit lasting 5 ms turns off
// RULE_04 - auto-restart: switch on again after 640 ms
// RULE_05 - latch-off: stays off until enable cycled
// RULE_06 - blanking: flag asserts when blanking trips
// RULE_07 - non-blanking: overcurrent never turns switch off
// RULE_08 - non-blanking: flag asserts when limiting starts
// RULE_09 - non-blanking: limiting ends by enable or thermal
// RULE_10 - turn-on after lockout is a controlled ramp
// RULE_11 - overtemperature holds off, recovers when cool
// RULE_12 - enable toggling cannot override overtemperature
// RULE_13 - enable low or good turn-on clears flag, timers
package lsfc_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_HZ = 1_000_000;
    localparam int TICK_DIV = CLK_HZ / TICK_HZ;
    localparam int DIV_W = 6;

    localparam int RAMP_TIME_MS = 1;
    localparam int BLANK_TIME_MS = 5;
    localparam int RESTART_TIME_MS = 640;
    localparam int RAMP_TICKS = RAMP_TIME_MS * (TICK_HZ / 1000);
    localparam int BLANK_TICKS = BLANK_TIME_MS * (TICK_HZ / 1000);
    localparam int RESTART_TICKS = RESTART_TIME_MS * (TICK_HZ / 1000);
    localparam int TMR_W = 20;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam logic [4:0] ADDR_CONFIG = 5'h00;
    localparam logic [4:0] ADDR_STATUS = 5'h04;
    localparam logic [4:0] ADDR_EVENT = 5'h08;
    localparam logic [4:0] ADDR_MASK = 5'h0c;
    localparam logic [4:0] ADDR_TRIPS = 5'h10;

    localparam int CFG_BLANK = 0;
    localparam int CFG_RESTART = 1;
    localparam int CFG_FLAGPIN = 2;
    localparam int CFG_W = 3;
    localparam logic [2:0] CONFIG_RESET = 3'h7;

    localparam int EV_LIMIT = 0;
    localparam int EV_TRIP = 1;
    localparam int EV_RESTART = 2;
    localparam int EV_THERM = 3;
    localparam int EV_UNDERVOLTAGE_LOCKOUT = 4;
    localparam int EV_W = 5;
    localparam logic [4:0] MASK_RESET = 5'h00;

    localparam int ST_STATE = 0;
    localparam int ST_SWITCH = 3;
    localparam int ST_FLAG = 4;
    localparam int ST_THERM = 5;
    localparam int ST_UNDERVOLTAGE_LOCKOUT = 6;
    localparam int ST_ENABLE = 7;

    typedef enum logic [2:0] {
        S_OFF = 3'h0,
        S_RAMP = 3'h1,
        S_ON = 3'h2,
        S_LIMIT = 3'h3,
        S_WAIT = 3'h4,
        S_LATCH = 3'h5
    } lsfc_state_t;
endpackage

// ### design/lsfc_timer.sv
// lsfc_timer: tick counter that flags when a loaded limit has elapsed
// assumes tick is a one-cycle enable and start restarts the count
`timescale 1ns/1ps
`default_nettype none
module lsfc_timer #(
    parameter int TMR_W = lsfc_pkg::TMR_W
) (
    input wire logic sys_clk,
    input wire logic rstN,
    input wire logic tick,
    input wire logic start,
    input wire logic [TMR_W-1:0] limit,
    output logic done
);
    typedef struct packed {
        logic [TMR_W-1:0] cnt;
        logic done;
    } lsfc_tmr_t;

    lsfc_tmr_t r;
    lsfc_tmr_t next_r;

    if (TMR_W < 2) begin : g_bad_width
        $error("lsfc_timer: TMR_W too small");
    end

    always_comb begin
        next_r = r;
        if (start) begin
            next_r.cnt = '0;
            next_r.done = 1'b0;
        end else if (tick && !r.done) begin
            next_r.cnt = r.cnt + 1'b1;
            // a limit of zero never expires, the top refuses it
            next_r.done = (next_r.cnt >= limit) && (limit != '0);
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign done = r.done;
endmodule // lsfc_timer
`default_nettype wire

// ### design/lsfc_top.sv
// lsfc_top: enable, fault sequencing and register port of a load switch
// assumes comparator inputs and register strobes are synchronous to sys_clk
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lsfc_top #(
    parameter int DATA_W = lsfc_pkg::DATA_W,
    parameter int ADDR_W = lsfc_pkg::ADDR_W,
    parameter int TICK_DIV = lsfc_pkg::TICK_DIV,
    parameter int RAMP_TICKS = lsfc_pkg::RAMP_TICKS,
    parameter int BLANK_TICKS = lsfc_pkg::BLANK_TICKS,
    parameter int RESTART_TICKS = lsfc_pkg::RESTART_TICKS
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic hostEnable,
    input wire logic undervoltageLockout,
    input wire logic overTemp,
    input wire logic limitReached,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdData,
    output logic switchOn,
    output logic constCurrent,
    output logic rampActive,
    output logic faultFlagN,
    output logic irq
);
    localparam int TMR_W = lsfc_pkg::TMR_W;
    localparam int DIV_W = lsfc_pkg::DIV_W;
    localparam int EV_W = lsfc_pkg::EV_W;
    localparam int CFG_W = lsfc_pkg::CFG_W;

    typedef struct packed {
        lsfc_pkg::lsfc_state_t state;
        logic [DIV_W-1:0] div;
        logic tick;
        logic [CFG_W-1:0] cfg;
        logic [EV_W-1:0] ev;
        logic [EV_W-1:0] mask;
        logic [7:0] trips;
        logic thermSeen;
        logic uvloSeen;
        logic flagN;
        logic sw;
        logic cc;
        logic ramp;
        logic irq;
        logic [DATA_W-1:0] rd;
    } lsfc_regs_t;

    localparam lsfc_regs_t REGS_RESET = '{
        state: lsfc_pkg::S_OFF,
        div: '0,
        tick: 1'b0,
        cfg: lsfc_pkg::CONFIG_RESET,
        ev: '0,
        mask: lsfc_pkg::MASK_RESET,
        trips: 8'h00,
        thermSeen: 1'b0,
        uvloSeen: 1'b0,
        flagN: 1'b1,
        sw: 1'b0,
        cc: 1'b0,
        ramp: 1'b0,
        irq: 1'b0,
        rd: '0
    };

    if (DATA_W < 8) begin : g_bad_data
        $error("lsfc_top: DATA_W must be at least 8");
    end
    if (ADDR_W < 5) begin : g_bad_addr
        $error("lsfc_top: ADDR_W must be at least 5");
    end
    if (TICK_DIV < 2 || TICK_DIV > (1 << DIV_W)) begin : g_bad_div
        $error("lsfc_top: TICK_DIV out of range");
    end
    if (RAMP_TICKS < 1 || RAMP_TICKS >= (1 << TMR_W)) begin : g_bad_ramp
        $error("lsfc_top: RAMP_TICKS out of range");
    end
    if (BLANK_TICKS < 1 || BLANK_TICKS >= (1 << TMR_W)) begin : g_bad_blank
        $error("lsfc_top: BLANK_TICKS out of range");
    end
    if (RESTART_TICKS < 1 || RESTART_TICKS >= (1 << TMR_W)) begin : g_bad_restart
        $error("lsfc_top: RESTART_TICKS out of range");
    end

    function automatic logic hit(
        input logic [ADDR_W-1:0] a,
        input logic [4:0] off
    );
        return a == ADDR_W'(off);
    endfunction

    function automatic logic conducts(input lsfc_pkg::lsfc_state_t s);
        return (s == lsfc_pkg::S_RAMP) || (s == lsfc_pkg::S_ON)
            || (s == lsfc_pkg::S_LIMIT);
    endfunction

    // status view; fault bit reads high while the flag pin is low
    function automatic logic [7:0] status_byte(
        input lsfc_pkg::lsfc_state_t s,
        input logic sw,
        input logic flagN,
        input logic hot,
        input logic low,
        input logic en
    );
        logic [7:0] b;
        b = 8'h00;
        b[lsfc_pkg::ST_STATE +: 3] = s;
        b[lsfc_pkg::ST_SWITCH] = sw;
        b[lsfc_pkg::ST_FLAG] = ~flagN;
        b[lsfc_pkg::ST_THERM] = hot;
        b[lsfc_pkg::ST_UNDERVOLTAGE_LOCKOUT] = low;
        b[lsfc_pkg::ST_ENABLE] = en;
        return b;
    endfunction

    // a trip in the clearing cycle still counts, and the count never wraps
    function automatic logic [7:0] count_trips(
        input logic [7:0] cnt,
        input logic clr,
        input logic inc
    );
        logic [7:0] base;
        base = clr ? 8'h00 : cnt;
        return (inc && base != 8'hff) ? base + 8'h01 : base;
    endfunction

    logic [1:0] rstPipe;
    logic rstN;
    lsfc_regs_t r;
    lsfc_regs_t next_r;
    logic tmrStart;
    logic tmrDone;
    logic [TMR_W-1:0] tmrLimit;

    // reset enters asynchronously but is released on a clock edge
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstN = rstPipe[1];

    lsfc_timer #(
        .TMR_W(TMR_W)
    ) u_timer (
        .sys_clk(sys_clk),
        .rstN(rstN),
        .tick(r.tick),
        .start(tmrStart),
        .limit(tmrLimit),
        .done(tmrDone)
    );

    always_comb begin
        logic inhibit;
        logic blanking;
        logic autoRestart;
        logic flagPin;
        logic setFlag;
        logic [EV_W-1:0] evSet;
        logic [7:0] rdByte;
        inhibit = undervoltageLockout | overTemp;
        blanking = r.cfg[lsfc_pkg::CFG_BLANK];
        autoRestart = r.cfg[lsfc_pkg::CFG_RESTART];
        flagPin = r.cfg[lsfc_pkg::CFG_FLAGPIN];
        setFlag = 1'b0;
        evSet = '0;
        rdByte = 8'h00;
        next_r = r;

        // microsecond tick for every fault timer
        next_r.tick = 1'b0;
        if (r.div == DIV_W'(TICK_DIV - 1)) begin
            next_r.div = '0;
            next_r.tick = 1'b1;
        end else begin
            next_r.div = r.div + 1'b1;
        end

        // the timer limit follows the state it is timing
        unique case (r.state)
            lsfc_pkg::S_RAMP: tmrLimit = TMR_W'(RAMP_TICKS);
            lsfc_pkg::S_LIMIT: tmrLimit = TMR_W'(BLANK_TICKS);
            lsfc_pkg::S_WAIT: tmrLimit = TMR_W'(RESTART_TICKS);
            default: tmrLimit = '0;
        endcase

        unique case (r.state)
            lsfc_pkg::S_OFF: begin
                // overtemperature keeps it here whatever enable does
                if (hostEnable && !inhibit) begin // see RULE_12
                    next_r.state = lsfc_pkg::S_RAMP; // see RULE_10
                end
            end
            lsfc_pkg::S_RAMP: begin
                if (limitReached) begin
                    next_r.state = lsfc_pkg::S_LIMIT;
                end else if (tmrDone) begin
                    next_r.state = lsfc_pkg::S_ON; // see RULE_10
                end
            end
            lsfc_pkg::S_ON: begin
                if (limitReached) begin
                    next_r.state = lsfc_pkg::S_LIMIT;
                end
            end
            lsfc_pkg::S_LIMIT: begin
                if (blanking) begin
                    if (!limitReached) begin
                        next_r.state = lsfc_pkg::S_ON;
                    end else if (tmrDone) begin
                        evSet[lsfc_pkg::EV_TRIP] = 1'b1; // see RULE_03
                        setFlag = flagPin; // see RULE_06
                        if (autoRestart) begin
                            next_r.state = lsfc_pkg::S_WAIT; // see RULE_04
                        end else begin
                            next_r.state = lsfc_pkg::S_LATCH; // see RULE_05
                        end
                    end
                end
                // without blanking the limit state is left only below
            end
            lsfc_pkg::S_WAIT: begin
                // a finished wait holds off until inhibit is gone
                if (tmrDone && !inhibit) begin
                    next_r.state = lsfc_pkg::S_RAMP; // see RULE_04
                    evSet[lsfc_pkg::EV_RESTART] = 1'b1;
                end
            end
            lsfc_pkg::S_LATCH: begin
                // held off until enable drops, handled below
                next_r.state = lsfc_pkg::S_LATCH; // see RULE_05
            end
            default: begin
                next_r.state = lsfc_pkg::S_OFF;
            end
        endcase

        // lockout and thermal override enable in every variant
        if (conducts(r.state) && inhibit) begin
            next_r.state = lsfc_pkg::S_OFF; // see RULE_02, see RULE_11, see RULE_09
        end
        if (!hostEnable) begin
            next_r.state = lsfc_pkg::S_OFF; // see RULE_05, see RULE_09
        end

        if (next_r.state == lsfc_pkg::S_LIMIT && r.state != lsfc_pkg::S_LIMIT) begin
            evSet[lsfc_pkg::EV_LIMIT] = 1'b1;
            if (!blanking) begin
                setFlag = flagPin; // see RULE_08
            end
        end

        // a state change restarts the timer, so no stale count survives
        tmrStart = (next_r.state != r.state); // see RULE_13

        // flag clears on enable low or a completed turn-on
        if (!hostEnable) begin
            next_r.flagN = 1'b1; // see RULE_13
        end
        if (r.state == lsfc_pkg::S_RAMP && next_r.state == lsfc_pkg::S_ON) begin
            next_r.flagN = 1'b1; // see RULE_13
        end
        // a trip that enable low already ends raises no flag
        if (setFlag && hostEnable) begin
            next_r.flagN = 1'b0; // see RULE_06, see RULE_08
        end

        // drive outputs from the coming state so they sit in flops
        next_r.sw = conducts(next_r.state); // see RULE_01, see RULE_07
        next_r.cc = (next_r.state == lsfc_pkg::S_LIMIT); // see RULE_03, see RULE_07
        next_r.ramp = (next_r.state == lsfc_pkg::S_RAMP); // see RULE_10

        // comparator edges for the event register
        next_r.thermSeen = overTemp;
        next_r.uvloSeen = undervoltageLockout;
        if (overTemp && !r.thermSeen) begin
            evSet[lsfc_pkg::EV_THERM] = 1'b1;
        end
        if (undervoltageLockout && !r.uvloSeen) begin
            evSet[lsfc_pkg::EV_UNDERVOLTAGE_LOCKOUT] = 1'b1;
        end

        // saturating count of blanking trips, cleared by any write to the trips register
        next_r.trips = count_trips(r.trips, regWr && hit(regAddr, lsfc_pkg::ADDR_TRIPS),
            evSet[lsfc_pkg::EV_TRIP]);

        if (regWr && hit(regAddr, lsfc_pkg::ADDR_CONFIG)) begin
            next_r.cfg = regWrData[CFG_W-1:0];
        end
        if (regWr && hit(regAddr, lsfc_pkg::ADDR_MASK)) begin
            next_r.mask = regWrData[EV_W-1:0];
        end
        // write one to clear; a new event in the same cycle wins
        if (regWr && hit(regAddr, lsfc_pkg::ADDR_EVENT)) begin
            next_r.ev = r.ev & ~regWrData[EV_W-1:0];
        end
        next_r.ev = next_r.ev | evSet;
        next_r.irq = |(next_r.ev & next_r.mask);

        // read data live for exactly one cycle after the strobe
        if (regRd) begin
            if (hit(regAddr, lsfc_pkg::ADDR_CONFIG)) begin
                rdByte = 8'(r.cfg);
            end else if (hit(regAddr, lsfc_pkg::ADDR_STATUS)) begin
                rdByte = status_byte(r.state, r.sw, r.flagN, overTemp,
                    undervoltageLockout, hostEnable);
            end else if (hit(regAddr, lsfc_pkg::ADDR_EVENT)) begin
                rdByte = 8'(r.ev);
            end else if (hit(regAddr, lsfc_pkg::ADDR_MASK)) begin
                rdByte = 8'(r.mask);
            end else if (hit(regAddr, lsfc_pkg::ADDR_TRIPS)) begin
                rdByte = r.trips;
            end
        end
        next_r.rd = DATA_W'(rdByte);
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            r <= REGS_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign regRdData = r.rd;
    assign switchOn = r.sw;
    assign constCurrent = r.cc;
    assign rampActive = r.ramp;
    assign faultFlagN = r.flagN;
    assign irq = r.irq;
endmodule // lsfc_top
`default_nettype wire

// ### dv/lsfc_top_asserts.sv
// lsfc_top_asserts: port-level checks of the load switch control
// assumes binding onto lsfc_top; variant is tracked from config writes
`timescale 1ns/1ps
`default_nettype none
module lsfc_top_asserts #(
    parameter int ADDR_W = lsfc_pkg::ADDR_W,
    parameter int DATA_W = lsfc_pkg::DATA_W,
    parameter int TICK_DIV = lsfc_pkg::TICK_DIV,
    parameter int BLANK_TICKS = lsfc_pkg::BLANK_TICKS,
    parameter int RESTART_TICKS = lsfc_pkg::RESTART_TICKS
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic hostEnable,
    input wire logic undervoltageLockout,
    input wire logic overTemp,
    input wire logic limitReached,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic switchOn,
    input wire logic constCurrent,
    input wire logic rampActive,
    input wire logic faultFlagN
);
    // bounds allow one tick of phase for blanking, two for restart, plus pipeline slack
    localparam int BB = (BLANK_TICKS + 1) * TICK_DIV + 3;
    localparam int RB = (RESTART_TICKS + 2) * TICK_DIV + 4;
    logic [2:0] cfg;
    logic prevCc;
    logic prevOk;
    logic latched;
    int ccCnt;
    int waitCnt;
    wire logic inhibit = undervoltageLockout | overTemp;
    wire logic trip = prevCc & ~constCurrent & ~switchOn & prevOk;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg <= 3'h7;
            prevCc <= 1'b0;
            prevOk <= 1'b0;
            latched <= 1'b0;
            ccCnt <= 0;
            waitCnt <= 0;
        end else begin
            if (regWr && regAddr == '0) begin
                cfg <= regWrData[2:0];
            end
            prevCc <= constCurrent;
            prevOk <= hostEnable & ~inhibit;
            ccCnt <= (constCurrent && cfg[0]) ? ccCnt + 1 : 0;
            latched <= (trip && !cfg[1]) || (latched && hostEnable);
            // inhibit stops the restart watch rather than stretching it
            waitCnt <= ((trip && cfg[1]) || (waitCnt != 0 && !switchOn && hostEnable && !inhibit))
                ? waitCnt + 1 : 0;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    chk_inhibit_off: assert property (inhibit |=> !switchOn)
        else $error("switch on while inhibited");
    chk_enable_off: assert property (!hostEnable |=> !switchOn && faultFlagN)
        else $error("enable low left switch or flag");
    chk_on_holds: assert property (switchOn && hostEnable && !inhibit && !limitReached
        && !constCurrent |=> switchOn)
        else $error("switch dropped without fault");
    chk_ramp_first: assert property ($rose(switchOn) |-> rampActive)
        else $error("turn-on without ramp");
    chk_limit_cause: assert property ($rose(constCurrent) |-> $past(limitReached))
        else $error("limiting without limit input");
    chk_blank_time: assert property (ccCnt <= BB)
        else $error("blanking overran");
    chk_trip_flag: assert property (trip && cfg[2] |-> !faultFlagN)
        else $error("trip without flag");
    chk_nb_flag: assert property ($rose(constCurrent) && !cfg[0] && cfg[2] |-> !faultFlagN)
        else $error("limit start without flag");
    chk_nb_stay: assert property (constCurrent && !cfg[0] && hostEnable && !inhibit
        |=> constCurrent)
        else $error("non-blanking limit left");
    chk_restart_time: assert property (waitCnt <= RB)
        else $error("auto restart late");
    chk_latch_hold: assert property (latched |-> !switchOn)
        else $error("latched switch came on");
    chk_flag_clear: assert property ($fell(rampActive) && switchOn && !constCurrent
        |-> faultFlagN)
        else $error("flag kept after turn-on");
    cov_trip: cover property (trip);
    cov_nb_limit: cover property ($rose(constCurrent) && !cfg[0]);
    cov_ramp_done: cover property ($fell(rampActive) && switchOn);
endmodule // lsfc_top_asserts

bind lsfc_top lsfc_top_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .TICK_DIV(TICK_DIV),
    .BLANK_TICKS(BLANK_TICKS), .RESTART_TICKS(RESTART_TICKS)) chk (.sys_clk, .reset_n,
    .hostEnable, .undervoltageLockout, .overTemp, .limitReached, .regAddr, .regWrData,
    .regWr, .switchOn, .constCurrent, .rampActive, .faultFlagN);
`default_nettype wire

// ### dv/lsfc_load_model.sv
// lsfc_load_model: powered load that can be told to overdraw
// assumes the switch output is synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module lsfc_load_model (
    input wire logic sys_clk,
    input wire logic switchOn,
    input wire logic overload,
    output logic limitReached
);
    initial limitReached = 1'b0;
    // current reaches the limit only while the switch conducts
    always @(posedge sys_clk) begin
        limitReached <= switchOn & overload;
    end
endmodule // lsfc_load_model
`default_nettype wire

// ### dv/lsfc_top_tb.sv
// lsfc_top_tb: directed scenarios for the load switch control
// assumes shortened tick and timer parameters
`timescale 1ns/1ps
`default_nettype none
module lsfc_top_tb;
    localparam int TD = 2;
    localparam int BT = 5;
    localparam int RT = 8;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hostEnable = 1'b0;
    logic undervoltageLockout = 1'b0;
    logic overTemp = 1'b0;
    logic overload = 1'b0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [4:0] regAddr = 5'h00;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData;
    logic limitReached, switchOn, constCurrent, rampActive, faultFlagN, irq;
    int badCount = 0;
    int checked = 0;
    int n;
    always #12.5 sys_clk = ~sys_clk;
    lsfc_top #(.TICK_DIV(TD), .RAMP_TICKS(3), .BLANK_TICKS(BT), .RESTART_TICKS(RT)) dut (
        .sys_clk, .reset_n, .hostEnable, .undervoltageLockout, .overTemp, .limitReached,
        .regAddr, .regWrData, .regWr, .regRd, .regRdData, .switchOn, .constCurrent,
        .rampActive, .faultFlagN, .irq);
    lsfc_load_model load (.sys_clk, .switchOn, .overload, .limitReached);
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string w);
        checked++;
        if (got !== exp) begin
            badCount++;
            $display("ERROR %0t %s got %h exp %h", $time, w, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string w);
        chk8({7'h00, got}, {7'h00, exp}, w);
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e, input string w);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        @(negedge sys_clk);
        chk8(regRdData, e, w);
    endtask
    task automatic wait_sw(input logic v, input int lim, output int k);
        k = 0;
        while (switchOn !== v) begin
            @(negedge sys_clk);
            k++;
            if (k > lim) begin
                badCount++;
                $display("ERROR %0t switch wait timed out", $time);
                finish_test();
            end
        end
    endtask
    task automatic enable(input logic v);
        @(posedge sys_clk);
        hostEnable <= v;
    endtask
    task automatic t_regs();
        rd(5'h00, 8'h07, "config");
        rd(5'h0c, 8'h00, "mask");
        rd(5'h08, 8'h00, "event");
        rd(5'h10, 8'h00, "trips");
        rd(5'h14, 8'h00, "unmapped");
        wr(5'h0c, 8'h03);
        rd(5'h0c, 8'h03, "mask back");
    endtask
    task automatic t_on();
        enable(1'b1);
        wait_sw(1'b1, 4, n);
        chk1(rampActive, 1'b1, "ramp");
        settle(5 * TD + 3);
        chk1(rampActive, 1'b0, "ramp end");
        chk1(switchOn, 1'b1, "stays on");
        enable(1'b0);
    endtask
    task automatic trip(input logic [7:0] cfg);
        wr(5'h00, cfg);
        enable(1'b1);
        wait_sw(1'b1, 4, n);
        @(posedge sys_clk);
        overload <= 1'b1;
        settle(2);
        chk1(constCurrent, 1'b1, "limiting");
        wait_sw(1'b0, (BT + 1) * TD + 3, n);
        chk1(n >= (BT - 1) * TD - 1, 1'b1, "blank early");
        chk1(faultFlagN, 1'b0, "trip flag");
        @(posedge sys_clk);
        overload <= 1'b0;
    endtask
    task automatic t_latch();
        trip(8'h05);
        settle(3 * RT * TD);
        chk1(switchOn, 1'b0, "latched");
        rd(5'h10, 8'h01, "trips");
        rd(5'h04, 8'h95, "status latched");
        wr(5'h10, 8'h00);
        rd(5'h10, 8'h00, "trips clear");
        rd(5'h08, 8'h03, "events");
        chk1(irq, 1'b1, "irq");
        wr(5'h0c, 8'h00);
        settle(1);
        chk1(irq, 1'b0, "irq masked");
        wr(5'h08, 8'h03);
        wr(5'h0c, 8'h03);
        settle(1);
        chk1(irq, 1'b0, "irq cleared");
        enable(1'b0);
        settle(1);
        chk1(faultFlagN, 1'b1, "flag off");
        enable(1'b1);
        wait_sw(1'b1, 4, n);
        enable(1'b0);
    endtask
    task automatic t_auto();
        trip(8'h07);
        wait_sw(1'b1, (RT + 2) * TD + 4, n);
        chk1(n >= (RT - 1) * TD, 1'b1, "restart early");
        chk1(faultFlagN, 1'b0, "flag in ramp");
        settle(5 * TD + 3);
        chk1(faultFlagN, 1'b1, "flag after on");
        enable(1'b0);
    endtask
    task automatic t_nb(input logic [7:0] cfg);
        wr(5'h00, cfg);
        enable(1'b1);
        wait_sw(1'b1, 4, n);
        @(posedge sys_clk);
        overload <= 1'b1;
        settle(2);
        chk1(faultFlagN, ~cfg[2], "nb flag");
        @(posedge sys_clk);
        overload <= 1'b0;
        settle(4 * BT * TD);
        chk1(constCurrent, 1'b1, "nb stays");
        chk1(switchOn, 1'b1, "nb on");
        enable(1'b0);
        settle(1);
        chk1(constCurrent, 1'b0, "nb left");
    endtask
    task automatic t_therm();
        wr(5'h08, 8'h1f);
        enable(1'b1);
        wait_sw(1'b1, 4, n);
        @(posedge sys_clk);
        overTemp <= 1'b1;
        settle(1);
        chk1(switchOn, 1'b0, "hot off");
        enable(1'b0);
        enable(1'b1);
        settle(10);
        chk1(switchOn, 1'b0, "toggle hot");
        @(posedge sys_clk);
        overTemp <= 1'b0;
        wait_sw(1'b1, 4, n);
        @(posedge sys_clk);
        undervoltageLockout <= 1'b1;
        settle(1);
        chk1(switchOn, 1'b0, "undervoltage_lockout off");
        @(posedge sys_clk);
        undervoltageLockout <= 1'b0;
        wait_sw(1'b1, 4, n);
        chk1(rampActive, 1'b1, "undervoltage_lockout ramp");
        rd(5'h08, 8'h18, "inhibit events");
        enable(1'b0);
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_regs();
        t_on();
        t_latch();
        t_auto();
        t_nb(8'h00);
        t_nb(8'h04);
        t_therm();
        finish_test();
    end
endmodule // lsfc_top_tb
`default_nettype wire
